//--- hdl/flash_reset_boot_sequencer.sv
// reset, boot copy and operation completion sequencer of the flash device
// assumes host bus and array data are synchronous to clock_in
`timescale 1ns/1ps
`default_nettype none

module flash_reset_boot_sequencer #(
	parameter int PROGRAM_SECTOR_CYCLES = flash_seq_pkg::PROGRAM_SECTOR_TIME_NS / flash_seq_pkg::CLOCK_PERIOD_NS,
	parameter int PROGRAM_PAGE_CYCLES   = flash_seq_pkg::PROGRAM_PAGE_TIME_NS / flash_seq_pkg::CLOCK_PERIOD_NS,
	parameter int ERASE_ONE_CYCLES      = flash_seq_pkg::ERASE_ONE_TIME_NS / flash_seq_pkg::CLOCK_PERIOD_NS,
	parameter int ERASE_MULTI_CYCLES    = flash_seq_pkg::ERASE_MULTI_TIME_NS / flash_seq_pkg::CLOCK_PERIOD_NS,
	parameter int SUSPEND_CYCLES        = flash_seq_pkg::SUSPEND_TIME_NS / flash_seq_pkg::CLOCK_PERIOD_NS,
	parameter int RESET_ERASE_CYCLES    = flash_seq_pkg::RESET_ERASE_TIME_NS / flash_seq_pkg::CLOCK_PERIOD_NS
) (
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic        enable_in,
	input  wire logic        reset_pin_n_in,
	input  wire logic        bus_write_in,
	input  wire logic        bus_read_in,
	input  wire logic [15:0] bus_addr_in,
	input  wire logic [15:0] bus_data_in,
	input  wire logic        op_start_in,
	input  wire logic [3:0]  op_code_in,
	input  wire logic [6:0]  op_blocks_in,
	input  wire logic        flag_clear_in,
	input  wire logic [15:0] copy_data_in,
	output logic             done_flag_out,
	output logic             resetting_out,
	output logic             boot_only_out,
	output logic             ready_out,
	output logic             busy_out,
	output logic             suspended_out,
	output logic             op_refused_out,
	output logic             copy_request_out,
	output logic [8:0]       copy_addr_out,
	output logic [15:0]      read_data_out,
	output logic             read_valid_out,
	output logic             read_refused_out
);
	localparam int CW = flash_seq_pkg::COUNT_WIDTH;

	flash_seq_pkg::phase_e   phase;
	flash_seq_pkg::op_code_e op_kind;
	logic [CW-1:0] phase_count;
	logic [CW-1:0] recovery_cycles;
	logic [CW-1:0] op_count;
	logic          cold_boot;
	logic          pin_released;
	logic          pin_prev;
	logic          erase_multi;
	logic          op_finish;
	logic          read_pending;
	logic          boot_region;
	logic          cmd_reset;
	logic          reset_arrives;
	logic          op_accept;
	logic [CW-1:0] abort_cycles;
	logic [CW-1:0] op_cycles;

	boot_mem_if mem ();

	boot_buffer_mem #(
		.WORDS (flash_seq_pkg::BOOT_WORDS)
	) u_boot_buffer (
		.clock_in  (clock_in),
		.enable_in (enable_in),
		.mem       (mem.memory)
	);

	// ----------------------------------------------------------------
	// decode of host writes and reset sources
	// ----------------------------------------------------------------
	always_comb begin
		boot_region = (bus_addr_in <= flash_seq_pkg::BOOT_MAIN_LAST)
			|| (bus_addr_in >= flash_seq_pkg::BOOT_SPARE_FIRST
			&& bus_addr_in <= flash_seq_pkg::BOOT_SPARE_LAST);
		cmd_reset = bus_write_in
			&& ((boot_region && bus_data_in == flash_seq_pkg::CMD_RESET_REGION)
			|| (bus_addr_in == flash_seq_pkg::RESET_REG_ADDR
			&& bus_data_in == flash_seq_pkg::CMD_RESET_REG));
		// warm and hot resets only once the cold sequence has ended
		reset_arrives = !cold_boot && ((!reset_pin_n_in && pin_prev) || cmd_reset);
	end

	// recovery time chosen by what the reset interrupts
	always_comb begin
		abort_cycles = CW'(flash_seq_pkg::RESET_IDLE_CYCLES);
		if (busy_out) begin
			case (op_kind)
				flash_seq_pkg::OP_LOAD_SECTOR, flash_seq_pkg::OP_LOAD_PAGE,
				flash_seq_pkg::OP_ERASE_VERIFY: begin
					abort_cycles = CW'(flash_seq_pkg::RESET_LOAD_CYCLES);
				end
				flash_seq_pkg::OP_PROGRAM_SECTOR, flash_seq_pkg::OP_PROGRAM_PAGE: begin
					abort_cycles = CW'(flash_seq_pkg::RESET_PROGRAM_CYCLES);
				end
				flash_seq_pkg::OP_ERASE, flash_seq_pkg::OP_ERASE_SUSPEND,
				flash_seq_pkg::OP_ERASE_RESUME: begin
					abort_cycles = CW'(RESET_ERASE_CYCLES);
				end
				default: begin
					abort_cycles = CW'(flash_seq_pkg::RESET_IDLE_CYCLES);
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// reset and boot phases
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			phase <= flash_seq_pkg::PH_POWER_WAIT;
			phase_count <= '0;
			recovery_cycles <= '0;
			cold_boot <= 1'b1;
		end else if (enable_in) begin
			if (reset_arrives) begin
				phase <= flash_seq_pkg::PH_RESETTING;
				phase_count <= '0;
				recovery_cycles <= abort_cycles;
			end else begin
				case (phase)
					flash_seq_pkg::PH_POWER_WAIT: begin
						phase_count <= phase_count + 1'b1;
						if (phase_count == CW'(flash_seq_pkg::POWER_ON_WAIT_CYCLES - 1)) begin
							phase <= flash_seq_pkg::PH_COPY;
							phase_count <= '0;
						end
					end
					flash_seq_pkg::PH_COPY: begin
						phase_count <= phase_count + 1'b1;
						if (phase_count == CW'(flash_seq_pkg::BOOT_COPY_CYCLES - 1)) begin
							phase <= flash_seq_pkg::PH_BOOT_ONLY;
						end
					end
					flash_seq_pkg::PH_RESETTING: begin
						// the latch point is the pin's release; count only then
						if (!reset_pin_n_in) begin
							phase_count <= '0;
						end else begin
							phase_count <= phase_count + 1'b1;
							if (phase_count == CW'(flash_seq_pkg::BOOT_ACCESS_CYCLES - 1)) begin
								phase <= flash_seq_pkg::PH_BOOT_ONLY;
							end
						end
					end
					flash_seq_pkg::PH_BOOT_ONLY: begin
						phase_count <= phase_count + 1'b1;
						if (cold_boot ? (pin_released && reset_pin_n_in)
							: (phase_count == recovery_cycles - 1'b1)) begin
							phase <= flash_seq_pkg::PH_READY;
							cold_boot <= 1'b0;
						end
					end
					flash_seq_pkg::PH_READY: begin
						phase_count <= '0;
					end
					default: begin
						phase <= flash_seq_pkg::PH_POWER_WAIT;
						phase_count <= '0;
					end
				endcase
			end
		end
	end

	// rising edge of the pin seen during the cold sequence
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			pin_prev <= 1'b0;
			pin_released <= 1'b0;
		end else if (enable_in) begin
			pin_prev <= reset_pin_n_in;
			if (!reset_pin_n_in) begin
				pin_released <= 1'b0;
			end else if (!pin_prev) begin
				pin_released <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// internal operations
	// ----------------------------------------------------------------
	always_comb begin
		op_cycles = CW'(flash_seq_pkg::LOCK_CYCLES);
		case (op_code_in)
			flash_seq_pkg::OP_LOAD_SECTOR:    op_cycles = CW'(flash_seq_pkg::LOAD_SECTOR_CYCLES);
			flash_seq_pkg::OP_LOAD_PAGE:      op_cycles = CW'(flash_seq_pkg::LOAD_PAGE_CYCLES);
			flash_seq_pkg::OP_PROGRAM_SECTOR: op_cycles = CW'(PROGRAM_SECTOR_CYCLES);
			flash_seq_pkg::OP_PROGRAM_PAGE:   op_cycles = CW'(PROGRAM_PAGE_CYCLES);
			flash_seq_pkg::OP_ERASE: begin
				op_cycles = (op_blocks_in > 7'h01) ? CW'(ERASE_MULTI_CYCLES) : CW'(ERASE_ONE_CYCLES);
			end
			flash_seq_pkg::OP_ERASE_SUSPEND:  op_cycles = CW'(SUSPEND_CYCLES);
			flash_seq_pkg::OP_ERASE_RESUME: begin
				op_cycles = erase_multi ? CW'(ERASE_MULTI_CYCLES) : CW'(ERASE_ONE_CYCLES);
			end
			flash_seq_pkg::OP_LOCK:           op_cycles = CW'(flash_seq_pkg::LOCK_CYCLES);
			flash_seq_pkg::OP_OTP_ACCESS:     op_cycles = CW'(flash_seq_pkg::OTP_CYCLES);
			flash_seq_pkg::OP_ERASE_VERIFY:   op_cycles = CW'(flash_seq_pkg::VERIFY_CYCLES);
			default:                          op_cycles = CW'(flash_seq_pkg::LOCK_CYCLES);
		endcase
		// suspend only while erasing, resume only while suspended
		op_accept = 1'b0;
		if (op_start_in && phase == flash_seq_pkg::PH_READY && op_code_in <= 4'h9) begin
			if (op_code_in == 4'h5) begin
				op_accept = busy_out && (op_kind == flash_seq_pkg::OP_ERASE
					|| op_kind == flash_seq_pkg::OP_ERASE_RESUME);
			end else if (op_code_in == 4'h6) begin
				op_accept = !busy_out && suspended_out;
			end else begin
				op_accept = !busy_out && !suspended_out;
			end
		end
		// last busy cycle; the flag rises on the same edge as busy falls
		op_finish = busy_out && !op_accept && op_count == CW'(1);
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			busy_out <= 1'b0;
			suspended_out <= 1'b0;
			op_kind <= flash_seq_pkg::OP_LOAD_SECTOR;
			op_count <= '0;
			erase_multi <= 1'b0;
			op_refused_out <= 1'b0;
		end else if (enable_in) begin
			op_refused_out <= op_start_in && !op_accept && !reset_arrives;
			if (reset_arrives) begin
				busy_out <= 1'b0;
				suspended_out <= 1'b0;
				op_count <= '0;
			end else if (op_accept) begin
				busy_out <= 1'b1;
				op_kind <= flash_seq_pkg::op_code_e'(op_code_in);
				op_count <= op_cycles;
				if (op_code_in == 4'h4) begin
					erase_multi <= op_blocks_in > 7'h01;
				end
				if (op_code_in == 4'h6) begin
					suspended_out <= 1'b0;
				end
			end else if (busy_out) begin
				op_count <= op_count - 1'b1;
				if (op_count == CW'(1)) begin
					busy_out <= 1'b0;
					suspended_out <= op_kind == flash_seq_pkg::OP_ERASE_SUSPEND;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// completion flag (a set in the same cycle beats flag_clear_in or a start; a reset beats the set)
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			done_flag_out <= 1'b0;
		end else if (enable_in) begin
			if (reset_arrives) begin
				done_flag_out <= 1'b0;
			end else if (op_finish || (phase == flash_seq_pkg::PH_BOOT_ONLY
				&& (cold_boot ? (pin_released && reset_pin_n_in)
				: (phase_count == recovery_cycles - 1'b1)))) begin
				done_flag_out <= 1'b1;
			end else if (flag_clear_in || op_accept) begin
				done_flag_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// boot copy into the buffer and host reads
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			copy_request_out <= 1'b0;
			copy_addr_out <= '0;
		end else if (enable_in) begin
			copy_request_out <= phase == flash_seq_pkg::PH_COPY
				&& phase_count < CW'(flash_seq_pkg::COPY_WORDS);
			copy_addr_out <= phase_count[8:0];
		end
	end

	always_comb begin
		mem.write_en = copy_request_out;
		mem.write_index = {1'b0, copy_addr_out};
		mem.write_data = copy_data_in;
		mem.read_en = bus_read_in && boot_region && (phase == flash_seq_pkg::PH_BOOT_ONLY
			|| phase == flash_seq_pkg::PH_READY);
		mem.read_index = bus_addr_in[15] ? {1'b1, 5'h00, bus_addr_in[3:0]}
			: {1'b0, bus_addr_in[8:0]};
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			read_pending <= 1'b0;
			read_valid_out <= 1'b0;
			read_refused_out <= 1'b0;
			read_data_out <= '0;
		end else if (enable_in) begin
			read_pending <= mem.read_en;
			read_refused_out <= bus_read_in && !mem.read_en;
			read_valid_out <= read_pending;
			if (read_pending) begin
				read_data_out <= mem.read_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// phase outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			resetting_out <= 1'b0;
			boot_only_out <= 1'b0;
			ready_out <= 1'b0;
		end else if (enable_in) begin
			resetting_out <= reset_arrives || (phase == flash_seq_pkg::PH_RESETTING
				&& !(reset_pin_n_in && phase_count == CW'(flash_seq_pkg::BOOT_ACCESS_CYCLES - 1)));
			boot_only_out <= !reset_arrives && (phase == flash_seq_pkg::PH_BOOT_ONLY
				|| (phase == flash_seq_pkg::PH_RESETTING && reset_pin_n_in
				&& phase_count == CW'(flash_seq_pkg::BOOT_ACCESS_CYCLES - 1))
				|| (phase == flash_seq_pkg::PH_COPY
				&& phase_count == CW'(flash_seq_pkg::BOOT_COPY_CYCLES - 1)))
				&& !(phase == flash_seq_pkg::PH_BOOT_ONLY && (cold_boot
				? (pin_released && reset_pin_n_in) : (phase_count == recovery_cycles - 1'b1)));
			ready_out <= !reset_arrives && (phase == flash_seq_pkg::PH_READY
				|| (phase == flash_seq_pkg::PH_BOOT_ONLY && (cold_boot
				? (pin_released && reset_pin_n_in) : (phase_count == recovery_cycles - 1'b1))));
		end
	end
endmodule

`default_nettype wire

//--- hdl/flash_seq_pkg.sv
// constants, opcodes and state codes for the reset and boot sequencer
// assumes a 10 MHz controller clock; times other than program, erase, suspend, reset-erase and reset pulse width are converted to cycle counts here
package flash_seq_pkg;

	// ----------------------------------------------------------------
	// clock and times
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS       = 100;
	localparam int BOOT_ACCESS_TIME_NS   = 5000;
	localparam int RESET_LOAD_TIME_NS    = 10000;
	localparam int RESET_PROGRAM_TIME_NS = 20000;
	localparam int RESET_ERASE_TIME_NS   = 500000;
	localparam int RESET_IDLE_TIME_NS    = 10000;
	localparam int RESET_PULSE_WIDTH_NS  = 200;
	localparam int LOAD_SECTOR_TIME_NS   = 35000;
	localparam int LOAD_PAGE_TIME_NS     = 45000;
	localparam int PROGRAM_SECTOR_TIME_NS = 720000;
	localparam int PROGRAM_PAGE_TIME_NS  = 750000;
	localparam int ERASE_ONE_TIME_NS     = 3000000;
	localparam int ERASE_MULTI_TIME_NS   = 6000000;
	localparam int SUSPEND_TIME_NS       = 500000;
	localparam int LOCK_TIME_NS          = 700;
	localparam int OTP_TIME_NS           = 700;
	localparam int VERIFY_TIME_NS        = 100000;
	localparam int POWER_ON_WAIT_NS      = 400000;
	localparam int BOOT_COPY_TIME_NS     = 70000;

	// ----------------------------------------------------------------
	// cycle counts (longest times round down, least times round up)
	// ----------------------------------------------------------------
	localparam int BOOT_ACCESS_CYCLES   = BOOT_ACCESS_TIME_NS / CLOCK_PERIOD_NS;
	localparam int RESET_LOAD_CYCLES    = RESET_LOAD_TIME_NS / CLOCK_PERIOD_NS;
	localparam int RESET_PROGRAM_CYCLES = RESET_PROGRAM_TIME_NS / CLOCK_PERIOD_NS;
	localparam int RESET_IDLE_CYCLES    = RESET_IDLE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int LOAD_SECTOR_CYCLES   = LOAD_SECTOR_TIME_NS / CLOCK_PERIOD_NS;
	localparam int LOAD_PAGE_CYCLES     = LOAD_PAGE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int LOCK_CYCLES          = LOCK_TIME_NS / CLOCK_PERIOD_NS;
	localparam int OTP_CYCLES           = OTP_TIME_NS / CLOCK_PERIOD_NS;
	localparam int VERIFY_CYCLES        = VERIFY_TIME_NS / CLOCK_PERIOD_NS;
	localparam int POWER_ON_WAIT_CYCLES = (POWER_ON_WAIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int BOOT_COPY_CYCLES     = BOOT_COPY_TIME_NS / CLOCK_PERIOD_NS;

	// ----------------------------------------------------------------
	// widths and addresses
	// ----------------------------------------------------------------
	localparam int COUNT_WIDTH      = 24;
	localparam int DATA_WIDTH       = 16;
	localparam int ADDR_WIDTH       = 16;
	localparam int BOOT_INDEX_WIDTH = 10;
	localparam int BOOT_WORDS       = 528;
	localparam int COPY_WORDS       = 512;
	localparam int BLOCK_COUNT_WIDTH = 7;

	localparam logic [15:0] BOOT_MAIN_FIRST  = 16'h0000;
	localparam logic [15:0] BOOT_MAIN_LAST   = 16'h01FF;
	localparam logic [15:0] BOOT_SPARE_FIRST = 16'h8000;
	localparam logic [15:0] BOOT_SPARE_LAST  = 16'h800F;
	localparam logic [15:0] RESET_REG_ADDR   = 16'hF220;
	localparam logic [15:0] CMD_RESET_REGION = 16'h00F0;
	localparam logic [15:0] CMD_RESET_REG    = 16'h00F3;

	// ----------------------------------------------------------------
	// operations and phases
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_LOAD_SECTOR    = 4'h0,
		OP_LOAD_PAGE      = 4'h1,
		OP_PROGRAM_SECTOR = 4'h2,
		OP_PROGRAM_PAGE   = 4'h3,
		OP_ERASE          = 4'h4,
		OP_ERASE_SUSPEND  = 4'h5,
		OP_ERASE_RESUME   = 4'h6,
		OP_LOCK           = 4'h7,
		OP_OTP_ACCESS     = 4'h8,
		OP_ERASE_VERIFY   = 4'h9
	} op_code_e;

	typedef enum logic [4:0] {
		PH_POWER_WAIT = 5'h01,
		PH_COPY       = 5'h02,
		PH_RESETTING  = 5'h04,
		PH_BOOT_ONLY  = 5'h08,
		PH_READY      = 5'h10
	} phase_e;

endpackage

//--- hdl/boot_mem_if.sv
// bundle between the sequencer and its boot buffer memory
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none

interface boot_mem_if #(
	parameter int INDEX_WIDTH = flash_seq_pkg::BOOT_INDEX_WIDTH,
	parameter int DATA_WIDTH  = flash_seq_pkg::DATA_WIDTH
);
	logic                   write_en;
	logic [INDEX_WIDTH-1:0] write_index;
	logic [DATA_WIDTH-1:0]  write_data;
	logic                   read_en;
	logic [INDEX_WIDTH-1:0] read_index;
	logic [DATA_WIDTH-1:0]  read_data;

	modport owner (
		output write_en,
		output write_index,
		output write_data,
		output read_en,
		output read_index,
		input  read_data
	);

	modport memory (
		input  write_en,
		input  write_index,
		input  write_data,
		input  read_en,
		input  read_index,
		output read_data
	);
endinterface

`default_nettype wire

//--- hdl/boot_buffer_mem.sv
// boot buffer storage: one write port, one registered read port
// assumes one clock; contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none

module boot_buffer_mem #(
	parameter int WORDS = flash_seq_pkg::BOOT_WORDS
) (
	input  wire logic   clock_in,
	input  wire logic   enable_in,
	boot_mem_if.memory  mem
);
	logic [$bits(mem.write_data)-1:0] store [WORDS];

	// ----------------------------------------------------------------
	// write and registered read
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (enable_in && mem.write_en) begin
			store[mem.write_index] <= mem.write_data;
		end
	end

	always_ff @(posedge clock_in) begin
		if (enable_in && mem.read_en) begin
			mem.read_data <= store[mem.read_index];
		end
	end
endmodule

`default_nettype wire

//--- sim/flash_array_model.sv
// array side of the boot copy, one word per requested index
// assumes the word is taken in the request cycle
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input  wire logic        request_in,
	input  wire logic [8:0]  addr_in,
	output logic      [15:0] data_out
);
	logic [15:0] word;
	assign word = {7'h00, addr_in} ^ 16'h5A00;
	// no stale word outside a request
	assign data_out = request_in ? word : ~word;
endmodule
`default_nettype wire

//--- sim/flash_seq_sva.sv
// port assertions for the sequencer
// assumes checks pause while enable_in is low
`timescale 1ns/1ps
`default_nettype none
module flash_seq_sva #(
	parameter int RESET_ERASE_CYCLES = 120
) (
	input wire logic        clock_in,
	input wire logic        reset_in,
	input wire logic        enable_in,
	input wire logic        reset_pin_n_in,
	input wire logic        bus_read_in,
	input wire logic [15:0] bus_addr_in,
	input wire logic        op_start_in,
	input wire logic [3:0]  op_code_in,
	input wire logic        done_flag_out,
	input wire logic        resetting_out,
	input wire logic        boot_only_out,
	input wire logic        ready_out,
	input wire logic        busy_out,
	input wire logic        suspended_out,
	input wire logic        op_refused_out,
	input wire logic        read_valid_out,
	input wire logic        read_refused_out
);
	localparam int MAX_REC = RESET_ERASE_CYCLES > 200 ? RESET_ERASE_CYCLES : 200;
	logic in_region;
	logic can_start;
	assign in_region = bus_addr_in <= 16'h01FF || (bus_addr_in >= 16'h8000 && bus_addr_in <= 16'h800F);
	assign can_start = op_start_in && ready_out && !busy_out && !suspended_out;
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in || !enable_in);
	AST_READ_OK: assert property (bus_read_in && in_region && (boot_only_out || ready_out) |-> ##2 read_valid_out)
		else $error("accepted read gave no data");
	AST_READ_OUT: assert property (bus_read_in && !in_region |=> read_refused_out)
		else $error("read outside region not refused");
	AST_BOOT_TIME: assert property ($rose(resetting_out) && reset_pin_n_in |-> ##[1:50] boot_only_out)
		else $error("boot buffer reads late after reset");
	AST_BOOT_PIN: assert property (resetting_out && $rose(reset_pin_n_in) |-> ##[1:50] boot_only_out)
		else $error("boot buffer reads late after pin release");
	AST_DONE_TIME: assert property ($rose(resetting_out) |-> ##[1:MAX_REC] (ready_out && done_flag_out))
		else $error("reset recovery too long");
	AST_RESET_CLR: assert property (resetting_out |-> !done_flag_out && !busy_out)
		else $error("outputs not defaulted in reset");
	AST_SHORT_OP: assert property (can_start && op_code_in inside {4'h7, 4'h8} |-> ##1 busy_out ##7 (done_flag_out && !busy_out))
		else $error("short operation timing wrong");
	AST_LOAD_OP: assert property (can_start && op_code_in == 4'h0 |=> !done_flag_out ##[1:350] done_flag_out)
		else $error("sector load too long");
	AST_REFUSE: assert property (op_start_in && !ready_out |=> op_refused_out)
		else $error("start outside ready not refused");
endmodule
bind flash_reset_boot_sequencer flash_seq_sva #(.RESET_ERASE_CYCLES(RESET_ERASE_CYCLES)) i_sva (
	.clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in), .reset_pin_n_in(reset_pin_n_in),
	.bus_read_in(bus_read_in), .bus_addr_in(bus_addr_in),
	.op_start_in(op_start_in), .op_code_in(op_code_in), .done_flag_out(done_flag_out),
	.resetting_out(resetting_out), .boot_only_out(boot_only_out), .ready_out(ready_out), .busy_out(busy_out),
	.suspended_out(suspended_out), .op_refused_out(op_refused_out), .read_valid_out(read_valid_out),
	.read_refused_out(read_refused_out));
`default_nettype wire

//--- sim/tb_flash_reset_boot_sequencer.sv
// bench for the reset and boot sequencer
// assumes shortened program, erase and suspend counts
`timescale 1ns/1ps
`default_nettype none
module tb_flash_reset_boot_sequencer;
	logic        clock_in = 0, reset_in = 1, pin_n = 1, wr = 0, rd = 0, start = 0, clr = 0, en = 1, req;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, cdata, rdata;
	logic [3:0]  code = 4'h0;
	logic [6:0]  blocks = 7'h01;
	logic [8:0]  caddr;
	logic        done, rsting, bonly, ready, busy, susp, refused, rvalid, rref;
	int          failures = 0, compares = 0;
	always #50 clock_in = ~clock_in;
	flash_reset_boot_sequencer #(.PROGRAM_SECTOR_CYCLES(40), .PROGRAM_PAGE_CYCLES(45), .ERASE_ONE_CYCLES(60),
		.ERASE_MULTI_CYCLES(90), .SUSPEND_CYCLES(30), .RESET_ERASE_CYCLES(120)) i_dut (
		.clock_in(clock_in), .reset_in(reset_in), .enable_in(en), .reset_pin_n_in(pin_n), .bus_write_in(wr),
		.bus_read_in(rd), .bus_addr_in(addr), .bus_data_in(wdata), .op_start_in(start), .op_code_in(code),
		.op_blocks_in(blocks), .flag_clear_in(clr), .copy_data_in(cdata), .done_flag_out(done),
		.resetting_out(rsting), .boot_only_out(bonly), .ready_out(ready), .busy_out(busy), .suspended_out(susp),
		.op_refused_out(refused), .copy_request_out(req), .copy_addr_out(caddr), .read_data_out(rdata),
		.read_valid_out(rvalid), .read_refused_out(rref));
	flash_array_model i_array (.request_in(req), .addr_in(caddr), .data_out(cdata));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// strobes last one cycle
	task automatic tick(int n = 1);
		repeat (n) begin
			@(negedge clock_in);
			if (start) start = 0;
			if (wr) wr = 0;
			if (rd) rd = 0;
			if (clr) clr = 0;
		end
	endtask
	task automatic measure(bit want_boot, output int n);
		n = 0;
		do begin
			tick();
			n++;
		end while (!(want_boot ? bonly === 1'b1 : done === 1'b1) && n < 6000);
	endtask
	// mode 0 refused, 1 valid, 2 valid with data
	task automatic read_word(logic [15:0] a, logic [15:0] exp, int mode);
		addr = a;
		rd = 1;
		tick();
		if (mode == 0) check("read refused", rref, 1'b1);
		tick();
		if (mode != 0) check("read valid", rvalid, 1'b1);
		if (mode == 2) check("read data", rdata, exp);
	endtask
	task automatic issue(logic [3:0] c, logic [6:0] b);
		clr = 1;
		tick();
		code = c;
		blocks = b;
		start = 1;
	endtask
	task automatic run_op(logic [3:0] c, logic [6:0] b, int cycles);
		int n;
		issue(c, b);
		measure(0, n);
		check("op cycles", n, cycles + 1);
	endtask
	task automatic cold_boot();
		int n;
		rd = 1;
		tick();
		check("early read", rref, 1'b1);
		measure(1, n);
		check("power wait", n > 4000, 1'b1);
		tick();
		check("cold done", {ready, done}, 2'b11);
		read_word(16'h0005, 16'h5A05, 2);
		read_word(16'h01FF, 16'h5BFF, 2);
		read_word(16'h800F, 16'h0000, 1);
		read_word(16'h0200, 16'h0000, 0);
		read_word(16'h8010, 16'h0000, 0);
	endtask
	task automatic suspend_resume();
		int n;
		issue(4'h4, 7'h01);
		tick(10);
		issue(4'h5, 7'h01);
		measure(0, n);
		check("suspend cycles", n, 31);
		check("suspended", susp, 1'b1);
		run_op(4'h6, 7'h01, 60);
		check("resumed", susp, 1'b0);
	endtask
	// clock enable low for three edges stretches a lock by three cycles
	task automatic freeze();
		int n;
		issue(4'h7, 7'h01);
		tick();
		en = 0;
		tick(3);
		check("frozen", {busy, done}, 2'b10);
		en = 1;
		measure(0, n);
		check("frozen op", n, flash_seq_pkg::LOCK_CYCLES);
	endtask
	task automatic warm(bit use_pin, logic [3:0] c, logic [15:0] a, logic [15:0] d, int r);
		int n1, n2;
		if (c != 4'hF) issue(c, 7'h01);
		tick(3);
		if (use_pin) begin
			pin_n = 0;
			tick(2);
			pin_n = 1;
		end else begin
			addr = a;
			wdata = d;
			wr = 1;
		end
		tick();
		check("resetting", {rsting, done}, 2'b10);
		code = 4'h7;
		start = 1;
		addr = 16'h0005;
		rd = 1;
		tick();
		check("refused in reset", {refused, rref}, 2'b11);
		// a pin reset latches on its last low edge, two edges before the check above
		measure(1, n1);
		check("boot access", n1 + 1 + int'(use_pin), flash_seq_pkg::BOOT_ACCESS_CYCLES);
		measure(0, n2);
		check("recovery", n1 + n2 + 1 + int'(use_pin), r);
		check("ready", ready, 1'b1);
		read_word(16'h0005, 16'h5A05, 2);
	endtask
	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		tick(6);
		reset_in = 0;
		cold_boot();
		run_op(4'h0, 7'h01, 350);
		run_op(4'h1, 7'h01, 450);
		run_op(4'h2, 7'h01, 40);
		run_op(4'h3, 7'h01, 45);
		run_op(4'h4, 7'h01, 60);
		run_op(4'h4, 7'h02, 90);
		run_op(4'h4, 7'h40, 90);
		run_op(4'h7, 7'h01, 7);
		run_op(4'h8, 7'h01, 7);
		run_op(4'h9, 7'h01, 1000);
		suspend_resume();
		freeze();
		warm(0, 4'hF, 16'hF220, 16'h00F3, 100);
		warm(0, 4'h0, 16'h0010, 16'h00F0, 100);
		warm(0, 4'h2, 16'h8003, 16'h00F0, 200);
		warm(1, 4'h4, 16'h0000, 16'h0000, 120);
		warm(1, 4'hF, 16'h0000, 16'h0000, 100);
		complete_run();
	end
	initial begin
		#2000000;
		failures++;
		complete_run();
	end
endmodule
`default_nettype wire
